// *** src/emr_regs.sv ***
/*
 Critical MSI attribute control register and affinity descriptor.
 Assumes a simple same-clock register port: one-cycle read/write strobes,
 byte address, 32-bit data; affinity inputs are static straps on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module emr_regs #(
    parameter bit          HAS_CFG_REGS  = 1'b1,
    parameter bit          HAS_CRIT_IRQ  = 1'b1,
    parameter bit          RECOMMENDED   = 1'b1,
    parameter bit          CAN_DISABLE   = 1'b1,
    parameter bit          NS_WRITABLE   = 1'b0,
    parameter bit          NS_CONFIG     = 1'b1,
    parameter bit          SH_CONFIG     = 1'b1,
    parameter bit          MEM_CONFIG    = 1'b1,
    parameter bit          NS_RESET      = 1'b0,
    parameter logic [1:0]  SH_FIXED      = 2'h2,
    parameter logic [3:0]  MEM_FIXED     = 4'h0,
    parameter bit          NS_FIXED      = 1'b1,
    parameter logic [31:0] CUSTOM_RESET  = 32'h0000_0000,
    parameter bit          HAS_AFFINITY  = 1'b1,
    parameter bit          REV_1P1       = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             rvalid,
    input  wire logic [1:0]  aff_level,
    input  wire logic        aff_subset,
    input  wire logic [7:0]  cpu_l3,
    input  wire logic [7:0]  cpu_l2,
    input  wire logic [7:0]  cpu_l1,
    input  wire logic [7:0]  cpu_l0,
    input  wire logic        cpu_uni,
    input  wire logic        cpu_mt,
    input  wire logic [7:0]  subset_mask,
    output logic             msi_enable,
    output logic             msi_nonsecure,
    output logic [1:0]       coherence_domain,
    output logic [3:0]       memory_type_field
);
    localparam bit PRESENT = HAS_CFG_REGS && (HAS_CRIT_IRQ || !RECOMMENDED);

    typedef struct packed {
        logic [31:0] attr;
        logic [31:0] rdata;
        logic        rvalid;
    } emr_state_t;

    emr_state_t st;
    emr_state_t next_st;

    // Subset encoding of one 8-bit affinity field
    function automatic logic [7:0] enc_field(input logic [7:0] id, input logic [7:0] m);
        logic [7:0] low;
        low = m & (~m + 8'h01);
        enc_field = (id & ~((low << 1) - 8'h01)) | low;
    endfunction : enc_field

    logic [31:0] attr_view;
    logic [63:0] aff;
    logic        subset;
    logic        eff_en;
    logic [3:0]  eff_mem;
    logic [1:0]  eff_sh;

    always_comb begin
        attr_view = 32'h0000_0000;
        if (PRESENT) begin
            if (!RECOMMENDED) begin
                attr_view = st.attr;
            end else begin
                attr_view[emr_pkg::EN_BIT] = CAN_DISABLE & st.attr[emr_pkg::EN_BIT];
                attr_view[emr_pkg::NS_BIT] = NS_CONFIG & !NS_WRITABLE
                                             & st.attr[emr_pkg::NS_BIT];
                if (SH_CONFIG)
                    attr_view[emr_pkg::SH_HI:emr_pkg::SH_LO] =
                        st.attr[emr_pkg::SH_HI:emr_pkg::SH_LO];
                if (MEM_CONFIG)
                    attr_view[emr_pkg::MT_HI:emr_pkg::MT_LO] =
                        st.attr[emr_pkg::MT_HI:emr_pkg::MT_LO];
            end
        end
    end

    always_comb begin
        aff    = 64'h0;
        subset = aff_subset & REV_1P1;
        if (HAS_AFFINITY) begin
            aff[39:32] = cpu_l3;
            unique case (emr_pkg::emr_level_t'(aff_level))
                emr_pkg::EMR_L0: begin
                    if (subset) begin
                        aff[7:0]   = enc_field(cpu_l0, subset_mask);
                        aff[23:8]  = {cpu_l2, cpu_l1};
                    end else begin
                        aff[emr_pkg::F0V_BIT] = 1'b1;
                        aff[emr_pkg::UNI_BIT] = cpu_uni;
                        aff[emr_pkg::MTF_BIT] = cpu_mt;
                        aff[23:0] = {cpu_l2, cpu_l1, cpu_l0};
                    end
                end
                emr_pkg::EMR_L1: begin
                    aff[23:16] = cpu_l2;
                    if (subset)
                        aff[15:8] = enc_field(cpu_l1, subset_mask);
                    else begin
                        aff[15:8] = cpu_l1;
                        aff[7:0]  = emr_pkg::LEVEL_MARK;
                    end
                end
                emr_pkg::EMR_L2: begin
                    if (subset) begin
                        aff[23:16] = enc_field(cpu_l2, subset_mask);
                        aff[15:8]  = emr_pkg::ZERO8;
                    end else begin
                        aff[23:16] = cpu_l2;
                        aff[15:8]  = emr_pkg::LEVEL_MARK;
                    end
                end
                emr_pkg::EMR_L3: begin
                    aff[23:16] = emr_pkg::LEVEL_MARK;
                    aff[15:8]  = emr_pkg::ZERO8;
                end
            endcase
        end
    end

    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        if (wr_en && addr == emr_pkg::ATTR_OFFSET && PRESENT) begin
            if (RECOMMENDED)
                next_st.attr = wdata & emr_pkg::ATTR_REC_MASK;
            else
                next_st.attr = wdata;
        end
        if (rd_en) begin
            next_st.rvalid = 1'b1;
            unique case (addr)
                emr_pkg::ATTR_OFFSET:   next_st.rdata = attr_view;
                emr_pkg::AFF_LO_OFFSET: next_st.rdata = aff[31:0];
                emr_pkg::AFF_HI_OFFSET: next_st.rdata = aff[63:32];
                default:                next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.attr   <= RECOMMENDED ? {25'h0, NS_RESET, 6'h00} : CUSTOM_RESET;
            st.rdata  <= 32'h0000_0000;
            st.rvalid <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Effective attributes used by the message writer
    always_comb begin
        eff_en  = !CAN_DISABLE | st.attr[emr_pkg::EN_BIT];
        eff_mem = MEM_CONFIG ? st.attr[emr_pkg::MT_HI:emr_pkg::MT_LO] : MEM_FIXED;
        eff_sh  = SH_CONFIG ? st.attr[emr_pkg::SH_HI:emr_pkg::SH_LO] : SH_FIXED;
        if (eff_mem <= emr_pkg::MEM_DEV_LAST || eff_mem == emr_pkg::MEM_NORMAL_NC)
            eff_sh = emr_pkg::SH_OUTER;
    end

    assign rdata             = st.rdata;
    assign rvalid            = st.rvalid;
    assign msi_enable        = PRESENT & eff_en;
    assign msi_nonsecure     = NS_WRITABLE ? 1'b1 :
                               (NS_CONFIG ? st.attr[emr_pkg::NS_BIT] : NS_FIXED);
    assign coherence_domain  = eff_sh;
    assign memory_type_field = eff_mem;

    a_enable_reset: assert property (@(posedge clk)
        $rose(nrst) |-> !st.attr[emr_pkg::EN_BIT] || !RECOMMENDED)
        else $error("enable not cleared by reset");
    a_write_lands: assert property (@(posedge clk) disable iff (!nrst)
        ce && wr_en && addr == emr_pkg::ATTR_OFFSET && PRESENT && RECOMMENDED
        |=> st.attr == ($past(wdata) & emr_pkg::ATTR_REC_MASK))
        else $error("attribute write lost");
    a_read_attr: assert property (@(posedge clk) disable iff (!nrst)
        ce && rd_en && addr == emr_pkg::ATTR_OFFSET |=> rvalid && rdata == $past(attr_view))
        else $error("attribute read wrong");
    a_absent_zero: assert property (@(posedge clk) disable iff (!nrst)
        rvalid && !PRESENT && $past(addr) == emr_pkg::ATTR_OFFSET |-> rdata == 32'h0)
        else $error("absent register not zero");
    a_shared_outer: assert property (@(posedge clk) disable iff (!nrst)
        memory_type_field <= emr_pkg::MEM_DEV_LAST |-> coherence_domain == emr_pkg::SH_OUTER)
        else $error("device memory not outer");
    a_ns_forced: assert property (@(posedge clk) disable iff (!nrst)
        NS_WRITABLE |-> msi_nonsecure && !attr_view[emr_pkg::NS_BIT])
        else $error("nonsecure forcing wrong");
    a_f0v_level: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY && aff[emr_pkg::F0V_BIT] |-> aff_level == 2'h0 && !subset)
        else $error("valid flag wrong");
    a_l3_mark: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY && aff_level == 2'h3 |-> aff[23:16] == emr_pkg::LEVEL_MARK)
        else $error("level three mark wrong");
    // A frozen clock enable holds rvalid high, so only a live idle cycle or a reset drops it
    a_rvalid_one: assert property (@(posedge clk) disable iff (!nrst)
        rvalid && ce && !rd_en |=> !rvalid)
        else $error("rvalid held");

    sequence s_attr_write;
        ce && wr_en && addr == emr_pkg::ATTR_OFFSET;
    endsequence : s_attr_write

    sequence s_aff_lo_read;
        ce && rd_en && addr == emr_pkg::AFF_LO_OFFSET;
    endsequence : s_aff_lo_read

    sequence s_aff_hi_read;
        ce && rd_en && addr == emr_pkg::AFF_HI_OFFSET;
    endsequence : s_aff_hi_read

    a_aff_lo_read: assert property (@(posedge clk) disable iff (!nrst)
        s_aff_lo_read |=> rvalid && rdata == $past(aff[31:0]))
        else $error("descriptor low word wrong");

    a_aff_hi_read: assert property (@(posedge clk) disable iff (!nrst)
        s_aff_hi_read |=> rvalid && rdata == $past(aff[63:32]))
        else $error("descriptor high word wrong");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
        ce && rd_en && addr != emr_pkg::ATTR_OFFSET && addr != emr_pkg::AFF_LO_OFFSET
        && addr != emr_pkg::AFF_HI_OFFSET |=> rvalid && rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_write_enable: assert property (@(posedge clk) disable iff (!nrst)
        s_attr_write && PRESENT && RECOMMENDED
        |=> msi_enable == ($past(wdata[emr_pkg::EN_BIT]) || !CAN_DISABLE))
        else $error("enable write not applied");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        RECOMMENDED |-> attr_view[31:8] == 24'h00_0000)
        else $error("reserved bits not zero");

    a_en_hidden: assert property (@(posedge clk) disable iff (!nrst)
        !CAN_DISABLE |-> !attr_view[emr_pkg::EN_BIT] && msi_enable == PRESENT)
        else $error("fixed enable wrong");

    a_ns_fixed: assert property (@(posedge clk) disable iff (!nrst)
        !NS_CONFIG |-> !attr_view[emr_pkg::NS_BIT])
        else $error("fixed security bit not zero");

    a_sh_fixed: assert property (@(posedge clk) disable iff (!nrst)
        !SH_CONFIG |-> attr_view[emr_pkg::SH_HI:emr_pkg::SH_LO] == 2'h0)
        else $error("fixed shareability not zero");

    a_mem_fixed: assert property (@(posedge clk) disable iff (!nrst)
        !MEM_CONFIG |-> attr_view[emr_pkg::MT_HI:emr_pkg::MT_LO] == 4'h0
        && memory_type_field == MEM_FIXED)
        else $error("fixed memory type wrong");

    a_nc_outer: assert property (@(posedge clk) disable iff (!nrst)
        memory_type_field == emr_pkg::MEM_NORMAL_NC |-> coherence_domain == emr_pkg::SH_OUTER)
        else $error("non-cacheable not outer");

    a_sh_follows: assert property (@(posedge clk) disable iff (!nrst)
        SH_CONFIG && memory_type_field > emr_pkg::MEM_DEV_LAST
        && memory_type_field != emr_pkg::MEM_NORMAL_NC
        |-> coherence_domain == st.attr[emr_pkg::SH_HI:emr_pkg::SH_LO])
        else $error("shareability not applied");

    a_mem_follows: assert property (@(posedge clk) disable iff (!nrst)
        MEM_CONFIG |-> memory_type_field == st.attr[emr_pkg::MT_HI:emr_pkg::MT_LO])
        else $error("memory type not applied");

    a_custom_view: assert property (@(posedge clk) disable iff (!nrst)
        PRESENT && !RECOMMENDED |-> attr_view == st.attr)
        else $error("custom view differs");

    // Frozen enable must hold every bit of state, read data included
    a_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> st == $past(st))
        else $error("state moved while frozen");

    a_aff_absent: assert property (@(posedge clk) disable iff (!nrst)
        !HAS_AFFINITY |-> aff == 64'h0)
        else $error("absent descriptor not zero");

    a_l0_copy: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY && aff_level == 2'h0 && !subset
        |-> aff[23:0] == {cpu_l2, cpu_l1, cpu_l0} && aff[emr_pkg::UNI_BIT] == cpu_uni
        && aff[emr_pkg::MTF_BIT] == cpu_mt)
        else $error("single element copy wrong");

    a_l3_field: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY |-> aff[39:32] == cpu_l3 && aff[63:40] == 24'h00_0000
        && aff[29:25] == 5'h00)
        else $error("upper descriptor wrong");

    a_l1_subset: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY && aff_level == 2'h1 && subset
        |-> aff[7:0] == emr_pkg::ZERO8 && !aff[emr_pkg::F0V_BIT])
        else $error("level one subset wrong");

    a_l1_copy: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY && aff_level == 2'h1 && !subset |-> aff[15:8] == cpu_l1)
        else $error("level one copy wrong");

    a_l2_mark: assert property (@(posedge clk) disable iff (!nrst)
        HAS_AFFINITY && aff_level == 2'h2
        |-> aff[15:8] == (subset ? emr_pkg::ZERO8 : emr_pkg::LEVEL_MARK))
        else $error("level two mark wrong");

    a_no_subset: assert property (@(posedge clk) disable iff (!nrst)
        !REV_1P1 |-> !subset)
        else $error("subset without revision");

    a_reset_quiet: assert property (@(posedge clk)
        !nrst |-> !rvalid && rdata == 32'h0000_0000)
        else $error("read port active in reset");
endmodule : emr_regs
`default_nettype wire

// *** common/emr_pkg.sv ***
/*
 Constants for the critical MSI attribute register and the affinity descriptor.
 Assumes a memory-mapped register window of 32-bit words at byte offsets.
*/
package emr_pkg;
    localparam logic [11:0] ATTR_OFFSET    = 12'heac;
    localparam logic [11:0] CFG5_HI_OFFSET = 12'heac;
    localparam logic [11:0] AFF_LO_OFFSET  = 12'hfa8;
    localparam logic [11:0] AFF_HI_OFFSET  = 12'hfac;
    localparam int EN_BIT  = 7;
    localparam int NS_BIT  = 6;
    localparam int SH_HI   = 5;
    localparam int SH_LO   = 4;
    localparam int MT_HI   = 3;
    localparam int MT_LO   = 0;
    localparam logic [31:0] ATTR_REC_MASK = 32'h0000_00ff;
    localparam logic [1:0] SH_NONE  = 2'h0;
    localparam logic [1:0] SH_OUTER = 2'h2;
    localparam logic [1:0] SH_INNER = 2'h3;
    localparam logic [3:0] MEM_DEV_LAST = 4'h3;
    localparam logic [3:0] MEM_NORMAL_NC = 4'h5;
    localparam logic [7:0] LEVEL_MARK = 8'h80;
    localparam logic [7:0] ZERO8      = 8'h00;
    localparam int F0V_BIT = 31;
    localparam int UNI_BIT = 30;
    localparam int MTF_BIT = 24;
    typedef enum logic [1:0] {EMR_L0, EMR_L1, EMR_L2, EMR_L3} emr_level_t;
endpackage : emr_pkg

// *** sim/tb_top.sv ***
/*
 Bench for emr_regs: attribute register and affinity descriptor.
 Assumes emr_pkg is compiled first; a second build has fixed fields.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ce = 1'b1;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [1:0]  aff_level = 2'h0;
    logic        aff_subset = 1'b0;
    logic [7:0]  cpu_l3 = 8'h5a, cpu_l2 = 8'hc3, cpu_l1 = 8'h96, cpu_l0 = 8'h3c;
    logic        cpu_uni = 1'b1, cpu_mt = 1'b1;
    logic [7:0]  subset_mask = 8'h04;
    logic [31:0] rdata, rdata_b, d, db, rdata_c, dc;
    logic        en_c;
    logic [1:0]  sh_tab [3] = '{2'h0, 2'h2, 2'h3};
    logic        rvalid, en, ns, en_b, ns_b;
    logic [1:0]  cd, cd_b;
    logic [3:0]  mt, mt_b;
    int          err_total = 0;
    int          total_checks = 0;

    always #2 clk = ~clk;

    emr_regs i_emr_regs (.clk, .nrst, .ce, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid,
        .aff_level, .aff_subset, .cpu_l3, .cpu_l2, .cpu_l1, .cpu_l0, .cpu_uni, .cpu_mt,
        .subset_mask, .msi_enable(en), .msi_nonsecure(ns), .coherence_domain(cd),
        .memory_type_field(mt));
    // Fixed-field build: no disable, non-secure writable, no attributes, no affinity
    emr_regs #(.CAN_DISABLE(1'b0), .NS_WRITABLE(1'b1), .SH_CONFIG(1'b0), .MEM_CONFIG(1'b0),
        .HAS_AFFINITY(1'b0)) i_emr_regs_fixed (.clk, .nrst, .ce, .wr_en, .rd_en, .addr,
        .wdata, .rdata(rdata_b), .rvalid(), .aff_level, .aff_subset, .cpu_l3, .cpu_l2,
        .cpu_l1, .cpu_l0, .cpu_uni, .cpu_mt, .subset_mask, .msi_enable(en_b),
        .msi_nonsecure(ns_b), .coherence_domain(cd_b), .memory_type_field(mt_b));
    // Absent build: no configuration registers, so the location reads zero
    emr_regs #(.HAS_CFG_REGS(1'b0)) i_emr_regs_absent (.clk, .nrst, .ce, .wr_en, .rd_en,
        .addr, .wdata, .rdata(rdata_c), .rvalid(), .aff_level, .aff_subset, .cpu_l3,
        .cpu_l2, .cpu_l1, .cpu_l0, .cpu_uni, .cpu_mt, .subset_mask, .msi_enable(en_c),
        .msi_nonsecure(), .coherence_domain(), .memory_type_field());

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    // One read; rvalid must pulse for exactly one cycle
    task automatic rd(input logic [11:0] a);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk("rvalid", {63'h0, rvalid}, 64'h1);
        d = rdata;
        db = rdata_b;
        dc = rdata_c;
        @(negedge clk);
        chk("rvalid_low", {63'h0, rvalid}, 64'h0);
    endtask : rd

    task automatic t_reset();
        @(negedge clk);
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        rd(12'heac);
        chk("attr_rst", d, 32'h0);
        chk("en_rst", {63'h0, en}, 64'h0);
    endtask : t_reset

    task automatic t_fields();
        wr(12'heac, 32'hffff_ffff);
        rd(12'heac);
        chk("attr_ff", d, 32'h0000_00ff);
        chk("outs", {en, ns, cd, mt}, 8'hff);
        chk("fixed_rd", db, 32'h0);
        chk("fixed_outs", {en_b, ns_b, cd_b, mt_b}, 8'he0);
        chk("fixed_en", {63'h0, en_b}, 64'h1);
        chk("absent_rd", dc, 32'h0);
        chk("absent_en", {63'h0, en_c}, 64'h0);
    endtask : t_fields

    // Device and non-cacheable normal types force outer sharing
    task automatic t_memtypes();
        for (int i = 0; i < 16; i++) begin
            wr(12'heac, 32'h30 | i);
            chk("mt", {60'h0, mt}, i);
            chk("cd", {62'h0, cd}, (i <= 3 || i == 5) ? 64'h2 : 64'h3);
        end
        foreach (sh_tab[j]) begin
            wr(12'heac, {26'h0, sh_tab[j], 4'hf});
            chk("sh", {62'h0, cd}, {62'h0, sh_tab[j]});
        end
    endtask : t_memtypes

    task automatic t_order();
        wr(12'heac, 32'h0000_0040);
        @(negedge clk);
        addr = 12'heac;
        wdata = 32'h0000_0080;
        wr_en = 1'b1;
        rd_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        chk("rd_old", rdata, 32'h40);
        chk("en_new", {en, ns}, 2'h2);
        wr(12'h100, 32'hff);
        ce = 1'b0;
        wr(12'heac, 32'h0f);
        ce = 1'b1;
        rd(12'heac);
        chk("kept", d, 32'h80);
        rd(12'h100);
        chk("unmapped", d, 32'h0);
    endtask : t_order

    // Bits 30 and 24 are only defined when the level-0 flag is set
    task automatic t_aff(input logic [1:0] lv, input logic sub, input logic [31:0] exp);
        logic [31:0] m;
        m = (lv == 2'h0 && !sub) ? 32'hffff_ffff : 32'hbeff_ffff;
        @(negedge clk);
        aff_level = lv;
        aff_subset = sub;
        rd(12'hfa8);
        chk("aff_lo", d & m, exp);
        chk("aff_abs", db, 32'h0);
        rd(12'hfac);
        chk("aff_hi", d, 32'h5a);
    endtask : t_aff

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    initial begin
        #20us;
        err_total++;
        complete_run();
    end

    initial begin
        t_reset();
        t_fields();
        t_memtypes();
        t_order();
        t_aff(2'h0, 1'b0, 32'hc1c3_963c);
        t_aff(2'h1, 1'b0, 32'h00c3_9680);
        t_aff(2'h2, 1'b0, 32'h00c3_8000);
        t_aff(2'h3, 1'b0, 32'h0080_0000);
        t_aff(2'h1, 1'b1, 32'h00c3_9400);
        t_aff(2'h2, 1'b1, 32'h00c4_0000);
        t_reset();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
